/* File: include/aprs_pkg.sv */
// shared constants and types of the audio pair routing select block
package aprs_pkg;

  // bus geometry: printed offsets are word indices, byte address is four times the index
  localparam int AXI_DATA_W = 32;
  localparam int AXI_ADDR_W = 18;
  localparam int SEL_W = 6;

  // register indices of the three selector banks
  localparam logic [15:0] IDX_CONV_IN = 16'hE080;
  localparam logic [15:0] IDX_CONV_RATE = 16'hE088;
  localparam logic [15:0] IDX_SER_OUT = 16'hE090;

  // bank sizes and converter grouping
  localparam int N_CONV_DEF = 8;
  localparam int N_SER_DEF = 12;
  localparam int GROUP_SIZE = 4;

  // selector field position and reset value
  localparam int SEL_LSB = 0;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h3F;

  // selector code boundaries
  localparam logic [SEL_W-1:0] SEL_SER_LAST = 6'h0B;
  localparam logic [SEL_W-1:0] SEL_DSP_FIRST = 6'h10;
  localparam logic [SEL_W-1:0] SEL_CONV_DSP_LAST = 6'h17;
  localparam logic [SEL_W-1:0] SEL_SPDIF = 6'h20;
  localparam logic [SEL_W-1:0] SEL_RATE_BASE = 6'h11;
  localparam logic [SEL_W-1:0] SEL_RATE_QUAD = 6'h13;
  localparam logic [SEL_W-1:0] SEL_OUT_DSP_LAST = 6'h1B;
  localparam logic [SEL_W-1:0] SEL_OUT_CONV_FIRST = 6'h20;
  localparam logic [SEL_W-1:0] SEL_OUT_CONV_LAST = 6'h27;

  // source kinds carried in a decoded route
  localparam logic [1:0] KIND_SERIAL = 2'h0;
  localparam logic [1:0] KIND_DSP = 2'h1;
  localparam logic [1:0] KIND_AUX = 2'h2; // spdif receiver, or internal rate in the rate bank
  localparam logic [1:0] KIND_CONV = 2'h3;

  // bank kinds of the decoder
  localparam int BANK_CONV_IN = 0;
  localparam int BANK_CONV_RATE = 1;
  localparam int BANK_SER_OUT = 2;

  // device variants
  localparam int VARIANT_INDEPENDENT = 0;
  localparam int VARIANT_GROUPED = 1;
  localparam int VARIANT_NO_CONV = 2;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one decoded destination: valid, source kind, source index
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [3:0] index;
  } aprs_route_type;

  localparam aprs_route_type ROUTE_NONE = '{valid: 1'b0, kind: 2'h0, index: 4'h0};

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } aprs_wr_state_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } aprs_rd_state_type;

endpackage : aprs_pkg

/* File: rtl/aprs_sel_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module aprs_sel_decode
  import aprs_pkg::*;
#(
  parameter int BANK = BANK_CONV_IN
) (
  input wire logic [SEL_W-1:0] code,
  input wire logic conv_present,
  output aprs_route_type route
);

  // undefined codes fall through to no route, same as the all-ones code
  always_comb begin
    route = ROUTE_NONE;
    case (BANK)
      BANK_CONV_IN: begin
        if (code <= SEL_SER_LAST) begin
          route = '{valid: 1'b1, kind: KIND_SERIAL, index: code[3:0]};
        end else if (code >= SEL_DSP_FIRST && code <= SEL_CONV_DSP_LAST) begin
          route = '{valid: 1'b1, kind: KIND_DSP, index: {1'b0, code[2:0]}};
        end else if (code == SEL_SPDIF) begin
          route = '{valid: 1'b1, kind: KIND_AUX, index: 4'h0};
        end
        if (!conv_present) begin
          route = ROUTE_NONE;
        end
      end
      BANK_CONV_RATE: begin
        if (code <= SEL_SER_LAST) begin
          route = '{valid: 1'b1, kind: KIND_SERIAL, index: code[3:0]};
        end else if (code == SEL_DSP_FIRST) begin
          route = '{valid: 1'b1, kind: KIND_DSP, index: 4'h0};
        end else if (code >= SEL_RATE_BASE && code <= SEL_RATE_QUAD) begin
          // index 0 internal_base_rate, 1 internal_double_rate, 2 internal_quad_rate
          route = '{valid: 1'b1, kind: KIND_AUX, index: {2'h0, 2'(code[1:0] - 2'h1)}};
        end
        if (!conv_present) begin
          route = ROUTE_NONE;
        end
      end
      BANK_SER_OUT: begin
        if (code >= SEL_DSP_FIRST && code <= SEL_OUT_DSP_LAST) begin
          route = '{valid: 1'b1, kind: KIND_DSP, index: code[3:0]};
        end else if (conv_present && code >= SEL_OUT_CONV_FIRST && code <= SEL_OUT_CONV_LAST) begin
          route = '{valid: 1'b1, kind: KIND_CONV, index: {1'b0, code[2:0]}};
        end
      end
      default: begin
        route = ROUTE_NONE;
      end
    endcase
  end

endmodule : aprs_sel_decode
`default_nettype wire

/* File: rtl/aprs_routing_select.sv */
`timescale 1ns/100ps
`default_nettype none
module aprs_routing_select
  import aprs_pkg::*;
#(
  parameter int VARIANT = VARIANT_INDEPENDENT,
  parameter int N_CONV = N_CONV_DEF,
  parameter int N_SER = N_SER_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output aprs_route_type [N_CONV-1:0] conv_in_route,
  output logic [N_CONV-1:0][2:0] conv_in_rate_ref,
  output aprs_route_type [N_CONV-1:0] conv_rate_route,
  output aprs_route_type [N_SER-1:0] ser_out_route
);

  localparam logic CONV_PRESENT = (VARIANT != VARIANT_NO_CONV);
  localparam logic GROUPED = (VARIANT == VARIANT_GROUPED);

  aprs_wr_state_type wr_state_ff;
  aprs_rd_state_type rd_state_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [AXI_DATA_W-1:0] rdata_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [15:0] waddr_idx_ff;
  logic [SEL_W-1:0] wdata_ff;
  logic wstrb_ff;
  logic [SEL_W-1:0] conv_in_sel_ff [N_CONV];
  logic [SEL_W-1:0] conv_rate_sel_ff [N_CONV];
  logic [SEL_W-1:0] ser_out_sel_ff [N_SER];
  aprs_route_type [N_CONV-1:0] conv_in_route_ff;
  aprs_route_type [N_CONV-1:0] conv_rate_route_ff;
  aprs_route_type [N_SER-1:0] ser_out_route_ff;
  logic [N_CONV-1:0][2:0] conv_in_rate_ref_ff;
  aprs_route_type [N_CONV-1:0] nxt_conv_in_route;
  aprs_route_type [N_CONV-1:0] nxt_conv_rate_route;
  aprs_route_type [N_SER-1:0] nxt_ser_out_route;
  logic [N_CONV-1:0][2:0] nxt_conv_in_rate_ref;
  logic aw_take;
  logic w_take;
  logic wr_commit;
  logic ar_take;
  logic [15:0] rd_idx;

  // bank membership of a word index
  function automatic logic in_conv_in(input logic [15:0] idx);
    in_conv_in = (idx >= IDX_CONV_IN) && (idx < IDX_CONV_IN + 16'(N_CONV));
  endfunction : in_conv_in

  function automatic logic in_conv_rate(input logic [15:0] idx);
    in_conv_rate = (idx >= IDX_CONV_RATE) && (idx < IDX_CONV_RATE + 16'(N_CONV));
  endfunction : in_conv_rate

  function automatic logic in_ser_out(input logic [15:0] idx);
    in_ser_out = (idx >= IDX_SER_OUT) && (idx < IDX_SER_OUT + 16'(N_SER));
  endfunction : in_ser_out

  // handshakes of the bus channels
  assign aw_take = s_axi_awvalid && awready_ff;
  assign w_take = s_axi_wvalid && wready_ff;
  assign wr_commit = (wr_state_ff == WR_COLLECT) && aw_held_ff && w_held_ff;
  assign ar_take = s_axi_arvalid && arready_ff;
  assign rd_idx = s_axi_araddr[AXI_ADDR_W-1:2];

  // write channel sequencing: address and data are caught in either order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_state_ff <= WR_COLLECT;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      case (wr_state_ff)
        WR_COLLECT: begin
          if (wr_commit) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (in_conv_in(waddr_idx_ff) || in_conv_rate(waddr_idx_ff) || in_ser_out(waddr_idx_ff))
                        ? RESP_OKAY : RESP_SLVERR;
            wr_state_ff <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
            wr_state_ff <= WR_COLLECT;
          end
        end
        default: begin
          wr_state_ff <= WR_COLLECT;
        end
      endcase
    end
  end

  // capture of write address and data; readies drop once each is held
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      waddr_idx_ff <= 16'h0000;
      wdata_ff <= 6'h00;
      wstrb_ff <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        waddr_idx_ff <= s_axi_awaddr[AXI_ADDR_W-1:2];
      end else if (wr_commit) begin
        aw_held_ff <= 1'b0;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[SEL_LSB +: SEL_W];
        wstrb_ff <= s_axi_wstrb[0];
      end else if (wr_commit) begin
        w_held_ff <= 1'b0;
      end
      awready_ff <= (wr_state_ff == WR_COLLECT) && !aw_held_ff && !aw_take;
      wready_ff <= (wr_state_ff == WR_COLLECT) && !w_held_ff && !w_take;
    end
  end

  // selector storage; only the six-bit selector field is stored, bits above it are reserved and dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < N_CONV; i++) begin
        conv_in_sel_ff[i] <= SEL_NONE;
        conv_rate_sel_ff[i] <= SEL_NONE;
      end
      for (int i = 0; i < N_SER; i++) begin
        ser_out_sel_ff[i] <= SEL_NONE;
      end
    end else if (wr_commit && wstrb_ff) begin
      if (in_conv_in(waddr_idx_ff)) begin
        conv_in_sel_ff[3'(waddr_idx_ff - IDX_CONV_IN)] <= wdata_ff;
      end
      if (in_conv_rate(waddr_idx_ff)) begin
        conv_rate_sel_ff[3'(waddr_idx_ff - IDX_CONV_RATE)] <= wdata_ff;
      end
      if (in_ser_out(waddr_idx_ff)) begin
        ser_out_sel_ff[4'(waddr_idx_ff - IDX_SER_OUT)] <= wdata_ff;
      end
    end
  end

  // read channel: one word per request, data registered with the answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_state_ff <= RD_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else begin
      case (rd_state_ff)
        RD_IDLE: begin
          arready_ff <= !ar_take;
          if (ar_take) begin
            rvalid_ff <= 1'b1;
            rd_state_ff <= RD_DATA;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h00000000;
            if (in_conv_in(rd_idx)) begin
              rdata_ff[SEL_LSB +: SEL_W] <= conv_in_sel_ff[3'(rd_idx - IDX_CONV_IN)];
            end else if (in_conv_rate(rd_idx)) begin
              rdata_ff[SEL_LSB +: SEL_W] <= conv_rate_sel_ff[3'(rd_idx - IDX_CONV_RATE)];
            end else if (in_ser_out(rd_idx)) begin
              rdata_ff[SEL_LSB +: SEL_W] <= ser_out_sel_ff[4'(rd_idx - IDX_SER_OUT)];
            end else begin
              rresp_ff <= RESP_SLVERR;
            end
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
            rd_state_ff <= RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= RD_IDLE;
        end
      endcase
    end
  end

  // one decoder per selector; grouped converters share their leader's rate code
  for (genvar i = 0; i < N_CONV; i++) begin : g_conv
    localparam int LEAD = GROUPED ? (i / GROUP_SIZE) * GROUP_SIZE : i;
    aprs_sel_decode #(.BANK(BANK_CONV_IN)) u_in_dec (
      .code(conv_in_sel_ff[i]),
      .conv_present(CONV_PRESENT),
      .route(nxt_conv_in_route[i])
    );
    aprs_sel_decode #(.BANK(BANK_CONV_RATE)) u_rate_dec (
      .code(conv_rate_sel_ff[LEAD]),
      .conv_present(CONV_PRESENT),
      .route(nxt_conv_rate_route[i])
    );
    assign nxt_conv_in_rate_ref[i] = 3'(LEAD);
  end

  for (genvar i = 0; i < N_SER; i++) begin : g_ser
    aprs_sel_decode #(.BANK(BANK_SER_OUT)) u_out_dec (
      .code(ser_out_sel_ff[i]),
      .conv_present(CONV_PRESENT),
      .route(nxt_ser_out_route[i])
    );
  end

  // decoded routes are registered so consumers see glitch-free selects
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_in_route_ff <= '{default: ROUTE_NONE};
      conv_rate_route_ff <= '{default: ROUTE_NONE};
      ser_out_route_ff <= '{default: ROUTE_NONE};
      conv_in_rate_ref_ff <= '0;
    end else begin
      conv_in_route_ff <= nxt_conv_in_route;
      conv_rate_route_ff <= nxt_conv_rate_route;
      ser_out_route_ff <= nxt_ser_out_route;
      conv_in_rate_ref_ff <= nxt_conv_in_rate_ref;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign conv_in_route = conv_in_route_ff;
  assign conv_rate_route = conv_rate_route_ff;
  assign ser_out_route = ser_out_route_ff;
  assign conv_in_rate_ref = conv_in_rate_ref_ff;

  // checks on a few lanes (converters 0, 1, 3, 4, 6, 7; serial outputs 0 and 4) stand for every lane
  in_serial_a: assert property (@(posedge clk) disable iff (sys_rst)
    (CONV_PRESENT && conv_in_sel_ff[0] <= SEL_SER_LAST) |=>
      conv_in_route_ff[0] == {1'b1, KIND_SERIAL, $past(conv_in_sel_ff[0][3:0])})
    else $error("converter input serial code decoded wrongly");

  in_dsp_a: assert property (@(posedge clk) disable iff (sys_rst)
    (CONV_PRESENT && conv_in_sel_ff[1] >= SEL_DSP_FIRST && conv_in_sel_ff[1] <= SEL_CONV_DSP_LAST) |=>
      conv_in_route_ff[1].valid && conv_in_route_ff[1].kind == KIND_DSP
      && conv_in_route_ff[1].index == {1'b0, $past(conv_in_sel_ff[1][2:0])})
    else $error("converter input dsp code decoded wrongly");

  in_spdif_a: assert property (@(posedge clk) disable iff (sys_rst)
    (CONV_PRESENT && conv_in_sel_ff[0] == SEL_SPDIF) |=>
      conv_in_route_ff[0] == {1'b1, KIND_AUX, 4'h0})
    else $error("spdif code not routed");

  sel_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> (conv_in_sel_ff[0] == SEL_NONE && ser_out_sel_ff[0] == SEL_NONE
      && conv_rate_sel_ff[0] == SEL_NONE && !conv_in_route_ff[0].valid && !ser_out_route_ff[0].valid))
    else $error("selectors not at none after reset");

  // sampled reset in the antecedent: the attempt at the release edge would still see reset values
  rate_group_a: assert property (@(posedge clk) disable iff (sys_rst)
    (GROUPED && !sys_rst) |-> ##1 (conv_rate_route_ff[3] == conv_rate_route_ff[0]
      && conv_rate_route_ff[7] == conv_rate_route_ff[4] && conv_in_rate_ref_ff[6] == 3'h4))
    else $error("grouped converter does not follow its leader");

  rate_internal_a: assert property (@(posedge clk) disable iff (sys_rst)
    (CONV_PRESENT && conv_rate_sel_ff[4] == SEL_RATE_QUAD) |=>
      conv_rate_route_ff[4] == {1'b1, KIND_AUX, 4'h2})
    else $error("quad rate code decoded wrongly");

  out_routes_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ser_out_sel_ff[0] >= SEL_OUT_CONV_FIRST && ser_out_sel_ff[0] <= SEL_OUT_CONV_LAST) |=>
      ser_out_route_ff[0].valid == CONV_PRESENT
      && (!CONV_PRESENT || ser_out_route_ff[0].kind == KIND_CONV))
    else $error("serial output converter code decoded wrongly");

  undef_code_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ser_out_sel_ff[4] > SEL_OUT_DSP_LAST && ser_out_sel_ff[4] < SEL_OUT_CONV_FIRST) |=>
      !ser_out_route_ff[4].valid)
    else $error("undefined code produced a route");

  no_conv_a: assert property (@(posedge clk) disable iff (sys_rst)
    !CONV_PRESENT |-> ##1 (!conv_in_route_ff[0].valid && !conv_rate_route_ff[0].valid))
    else $error("converter route active without converters");

  write_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_commit && wstrb_ff && waddr_idx_ff == IDX_CONV_IN + 16'h0007) |=>
      conv_in_sel_ff[7] == $past(wdata_ff) && s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("write to last input selector lost");

  read_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    ar_take |=> s_axi_rvalid && s_axi_rdata[AXI_DATA_W-1:SEL_W] == '0)
    else $error("read answer late or reserved bits set");

endmodule : aprs_routing_select
`default_nettype wire

/* File: verif/aprs_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module aprs_far_model
  import aprs_pkg::*;
#(
  parameter int N_CONV = N_CONV_DEF,
  parameter int N_SER = N_SER_DEF
) (
  input wire logic clk,
  input wire aprs_route_type [N_CONV-1:0] conv_in_route,
  input wire aprs_route_type [N_SER-1:0] ser_out_route,
  output logic [N_CONV-1:0][7:0] conv_in_sample,
  output logic [N_SER-1:0][7:0] ser_out_sample
);
  logic [6:0] noise_ff = 7'h00;

  // an unrouted pair shows a moving pattern, so a stale word never passes for data
  // every source runs off this one clock, so each converter group's inputs stay synchronous
  always @(posedge clk) begin
    noise_ff <= noise_ff + 7'h01;
  end

  // each source pair sends a word naming itself; converter outputs carry what was routed into them
  always_comb begin
    for (int i = 0; i < N_CONV; i++) begin
      conv_in_sample[i] = conv_in_route[i].valid ? {1'b1, conv_in_route[i].kind, 1'b0, conv_in_route[i].index}
                                                 : {1'b0, noise_ff};
    end
    for (int j = 0; j < N_SER; j++) begin
      if (ser_out_route[j].valid && ser_out_route[j].kind == KIND_CONV) begin
        ser_out_sample[j] = conv_in_sample[ser_out_route[j].index[2:0]];
      end else if (ser_out_route[j].valid) begin
        ser_out_sample[j] = {1'b1, ser_out_route[j].kind, 1'b0, ser_out_route[j].index};
      end else begin
        ser_out_sample[j] = {1'b0, noise_ff};
      end
    end
  end
endmodule : aprs_far_model
`default_nettype wire

/* File: verif/aprs_routing_select_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module aprs_routing_select_test
  import aprs_pkg::*;
();
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [AXI_ADDR_W-1:0] awaddr = '0;
  logic [AXI_ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  aprs_route_type [7:0] cin_r, crate_r, gin_r, grate_r, nin_r, nrate_r;
  aprs_route_type [11:0] ser_r, gser_r, nser_r;
  logic [7:0][2:0] cref, gref;
  logic [7:0][7:0] cin_s;
  logic [11:0][7:0] ser_s;
  logic [5:0] shadow [3][12];
  int failures = 0;
  int n_compared = 0;

  // three variants share one bus; only the first answers are judged, the others differ in routes
  aprs_routing_select #(.VARIANT(VARIANT_INDEPENDENT)) DUT (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv_in_route(cin_r), .conv_in_rate_ref(cref), .conv_rate_route(crate_r),
    .ser_out_route(ser_r));
  aprs_routing_select #(.VARIANT(VARIANT_GROUPED)) DUT_G (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .conv_in_route(gin_r),
    .conv_in_rate_ref(gref), .conv_rate_route(grate_r), .ser_out_route(gser_r));
  aprs_routing_select #(.VARIANT(VARIANT_NO_CONV)) DUT_N (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .conv_in_route(nin_r),
    .conv_in_rate_ref(), .conv_rate_route(nrate_r), .ser_out_route(nser_r));
  aprs_far_model FAR (.clk(clk), .conv_in_route(cin_r), .ser_out_route(ser_r), .conv_in_sample(cin_s),
    .ser_out_sample(ser_s));

  // clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] base(input int b);
    return (b == 0) ? IDX_CONV_IN : (b == 1) ? IDX_CONV_RATE : IDX_SER_OUT;
  endfunction : base

  function automatic int nl(input int b);
    return (b == BANK_SER_OUT) ? 12 : 8;
  endfunction : nl

  // expected route of a selector code; anything unlisted decodes to no route
  function automatic aprs_route_type exp_route(input int b, input logic [5:0] c);
    aprs_route_type e;
    e = ROUTE_NONE;
    if (b != BANK_SER_OUT && c <= SEL_SER_LAST) e = '{1'b1, KIND_SERIAL, c[3:0]};
    if (b == BANK_CONV_IN && c >= SEL_DSP_FIRST && c <= SEL_CONV_DSP_LAST) e = '{1'b1, KIND_DSP, 4'(c - SEL_DSP_FIRST)};
    if (b == BANK_CONV_IN && c == SEL_SPDIF) e = '{1'b1, KIND_AUX, 4'h0};
    if (b == BANK_CONV_RATE && c == SEL_DSP_FIRST) e = '{1'b1, KIND_DSP, 4'h0};
    if (b == BANK_CONV_RATE && c >= SEL_RATE_BASE && c <= SEL_RATE_QUAD) e = '{1'b1, KIND_AUX, 4'(c - SEL_RATE_BASE)};
    if (b == BANK_SER_OUT && c >= SEL_DSP_FIRST && c <= SEL_OUT_DSP_LAST) e = '{1'b1, KIND_DSP, 4'(c - SEL_DSP_FIRST)};
    if (b == BANK_SER_OUT && c >= SEL_OUT_CONV_FIRST && c <= SEL_OUT_CONV_LAST) e = '{1'b1, KIND_CONV, 4'(c - SEL_OUT_CONV_FIRST)};
    return e;
  endfunction : exp_route

  function automatic logic [7:0] smp(input aprs_route_type e);
    return {1'b1, e.kind, 1'b0, e.index};
  endfunction : smp

  // write master: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge clk);
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    r = bvalid ? bresp : 2'bxx;
    bready <= 1'b0;
  endtask : axi_wr

  // read master; a missing answer yields unknowns that fail any compare
  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    d = rvalid ? rdata : 'x;
    r = rvalid ? rresp : 2'bxx;
    rready <= 1'b0;
  endtask : axi_rd

  // judge every route of all variants against the shadow copy of the selectors
  task automatic chk_routes();
    aprs_route_type e;
    aprs_route_type ce;
    @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      e = exp_route(0, shadow[0][i]);
      `CHK(cin_r[i], e)
      `CHK(gin_r[i], e)
      `CHK(nin_r[i], ROUTE_NONE)
      if (e.valid) `CHK(cin_s[i], smp(e))
      `CHK(crate_r[i], exp_route(1, shadow[1][i]))
      `CHK(grate_r[i], exp_route(1, shadow[1][i & 4]))
      `CHK(nrate_r[i], ROUTE_NONE)
      `CHK(cref[i], 3'(i))
      `CHK(gref[i], 3'(i & 4))
    end
    for (int j = 0; j < 12; j++) begin
      e = exp_route(2, shadow[2][j]);
      ce = exp_route(0, shadow[0][e.index[2:0]]);
      `CHK(ser_r[j], e)
      `CHK(gser_r[j], e)
      `CHK(nser_r[j], (e.kind == KIND_CONV) ? ROUTE_NONE : e)
      if (e.valid && e.kind != KIND_CONV) `CHK(ser_s[j], smp(e))
      if (e.valid && e.kind == KIND_CONV && ce.valid) `CHK(ser_s[j], smp(ce))
    end
  endtask : chk_routes

  // store one selector with reserved bits set, read it back, then judge routes
  task automatic put(input int b, input int lane, input logic [5:0] c);
    logic [1:0] r;
    logic [31:0] d;
    axi_wr(base(b) + 16'(lane), {26'h3FFFFFF, c}, 4'hF, r);
    `CHK(r, RESP_OKAY)
    shadow[b][lane] = c;
    axi_rd(base(b) + 16'(lane), d, r);
    `CHK(d, {26'h0, c})
    chk_routes();
  endtask : put

  // every selector reads 3Fh after reset and nothing is routed
  task automatic t_reset();
    logic [1:0] r;
    logic [31:0] d;
    for (int b = 0; b < 3; b++) begin
      for (int i = 0; i < nl(b); i++) begin
        shadow[b][i] = SEL_NONE;
        axi_rd(base(b) + 16'(i), d, r);
        `CHK(d, 32'h0000003F)
        `CHK(r, RESP_OKAY)
      end
    end
    chk_routes();
  endtask : t_reset

  // all 64 codes through each bank; converter inputs first given live sources
  task automatic t_codes();
    for (int b = 0; b < 3; b++) begin
      if (b == BANK_SER_OUT) begin
        for (int i = 0; i < 8; i++) put(0, i, 6'(SEL_DSP_FIRST + i));
      end
      for (int c = 0; c < 64; c++) put(b, c % nl(b), 6'(c));
    end
  endtask : t_codes

  // masked write is ignored, unmapped places answer with an error and store nothing
  task automatic t_odd();
    logic [1:0] r;
    logic [31:0] d;
    put(BANK_CONV_RATE, 4, SEL_RATE_QUAD);
    axi_wr(IDX_SER_OUT, 32'h00000010, 4'hE, r);
    `CHK(r, RESP_OKAY)
    axi_rd(IDX_SER_OUT, d, r);
    `CHK(d, {26'h0, shadow[2][0]})
    axi_wr(IDX_SER_OUT + 16'h000C, 32'h00000010, 4'hF, r);
    `CHK(r, RESP_SLVERR)
    axi_rd(IDX_CONV_IN - 16'h0001, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h00000000)
    chk_routes();
  endtask : t_odd

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_codes();
    t_odd();
    test_done();
  end

  // the run needs about fifteen hundred cycles; this cuts a hang well beyond that
  initial begin
    #(25 * 20000);
    failures++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done();
  end
endmodule : aprs_routing_select_test
`default_nettype wire
